// ===== bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pwr_ctl_map.svh"
module tb_top;
	logic        i_mclk, i_rst, i_power_down_instruction, i_main_regulator_off_bit;
	logic        i_nmi_pin_n, i_rtc_irq, i_can_activity, i_i2c_activity, i_lp_osc_running;
	logic        i_lp_ref_disable, i_retained_ram_enable, i_core_supply_low;
	logic        i_main_supply_off, i_ram_write_n, i_ram_select, i_reset_input_pin_n;
	logic [15:0] i_system_control_register;
	logic [7:0]  i_irq_enable;
	logic [7:0]  i_irq_active_high;
	logic [7:0]  i_fast_external_irq_pin;
	logic        o_core_clk_en, o_main_osc_en, o_rtc_on_lp, o_rtc_count_en, o_pd_entered;
	logic        o_pd_refused, o_protected_active, o_ram_frozen, o_ram_on_standby_supply;
	logic        o_ram_write_n, o_ram_select, o_standby_retain_only;
	int          err_count = 0;
	int          n_compared = 0;
	int          n_ent = 0;
	int          n_ref = 0;
	wake_partner i_partner (.i_mclk, .o_reset_input_pin_n(i_reset_input_pin_n),
		.o_fast_external_irq_pin(i_fast_external_irq_pin));
	pwr_ctl #(.N_IRQ(8), .LP_DETECT(4)) i_dut (.i_mclk, .i_rst, .i_reset_input_pin_n,
		.i_power_down_instruction, .i_system_control_register, .i_main_regulator_off_bit,
		.i_nmi_pin_n, .i_fast_external_irq_pin, .i_irq_enable, .i_irq_active_high,
		.i_rtc_irq, .i_can_activity, .i_i2c_activity, .i_lp_osc_running, .i_lp_ref_disable,
		.i_retained_ram_enable, .i_core_supply_low, .i_main_supply_off, .i_ram_write_n,
		.i_ram_select, .o_core_clk_en, .o_main_osc_en, .o_rtc_on_lp, .o_rtc_count_en,
		.o_pd_entered, .o_pd_refused, .o_protected_active, .o_ram_frozen,
		.o_ram_on_standby_supply, .o_ram_write_n, .o_ram_select, .o_standby_retain_only);
	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		if (o_pd_entered === 1'b1) n_ent++;
		if (o_pd_refused === 1'b1) n_ref++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim();
		if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task automatic tick(input int n);
		repeat (n) @(negedge i_mclk);
	endtask : tick
	task automatic wait_run();
		int k;
		for (k = 0; k < 60 && o_core_clk_en !== 1'b1; k++) @(negedge i_mclk);
		chk(o_core_clk_en, 1'b1);
		if (o_core_clk_en !== 1'b1) end_sim();
	endtask : wait_run
	task automatic pd(input logic v, input logic exp);
		int e0;
		int r0;
		tick(3);
		e0 = n_ent;
		r0 = n_ref;
		i_system_control_register[`PD_VARIANT_BIT] = v;
		i_power_down_instruction = 1'b1;
		tick(1);
		i_power_down_instruction = 1'b0;
		tick(3);
		chk(n_ent - e0, exp);
		chk(n_ref - r0, !exp && i_main_regulator_off_bit);
		chk(o_core_clk_en, !exp);
	endtask : pd
	task automatic wake(input int src);
		case (src)
			0: begin
				i_partner.set_irq(src, 1'b1);
				tick(14);
				i_partner.set_irq(src, 1'b0);
			end
			4: begin
				i_partner.set_reset(1'b0);
				tick(4);
				i_partner.set_reset(1'b1);
			end
			default: begin
				{i_rtc_irq, i_can_activity, i_i2c_activity} = 3'h4 >> (src - 1);
				tick(2);
			end
		endcase
		wait_run();
		{i_rtc_irq, i_can_activity, i_i2c_activity} = 3'h0;
	endtask : wake
	task automatic stby(input logic cnt);
		i_retained_ram_enable = 1'b0;
		i_partner.set_reset(1'b0);
		tick(4);
		chk(o_ram_on_standby_supply, 1'b1);
		i_main_supply_off = 1'b1;
		tick(3);
		chk(o_standby_retain_only, 1'b1);
		chk(o_rtc_count_en, cnt);
		chk(o_ram_frozen, 1'b1);
		i_main_supply_off = 1'b0;
		tick(3);
		i_partner.set_reset(1'b1);
		wait_run();
		tick(5);
		chk(o_ram_on_standby_supply, 1'b0);
		chk(o_ram_frozen, 1'b1);
		i_retained_ram_enable = 1'b1;
	endtask : stby
	initial begin
		// Regulator-off bit starts set and is cleared for one power-down request only
		{i_rst, i_power_down_instruction, i_main_regulator_off_bit, i_nmi_pin_n, i_rtc_irq,
			i_can_activity, i_i2c_activity, i_lp_osc_running, i_lp_ref_disable,
			i_retained_ram_enable, i_core_supply_low, i_main_supply_off, i_ram_write_n,
			i_ram_select} = 14'h2c02;
		i_system_control_register = 16'h0000;
		i_irq_enable = 8'hff;
		i_irq_active_high = 8'hff;
		tick(4);
		i_rst = 1'b0;
		tick(2);
		i_partner.set_reset(1'b1);
		tick(5);
		chk(o_core_clk_en, 1'b1);
		chk(o_ram_frozen, 1'b1);
		chk(o_ram_on_standby_supply, 1'b0);
		{i_ram_write_n, i_ram_select} = 2'h1;
		tick(2);
		chk({o_ram_write_n, o_ram_select}, 2'h2);
		i_retained_ram_enable = 1'b1;
		tick(2);
		chk(o_ram_frozen, 1'b0);
		chk({o_ram_write_n, o_ram_select}, 2'h1);
		i_core_supply_low = 1'b1;
		tick(2);
		chk(o_ram_frozen, 1'b0);
		i_retained_ram_enable = 1'b0;
		tick(2);
		chk(o_ram_frozen, 1'b1);
		i_retained_ram_enable = 1'b1;
		tick(2);
		chk(o_ram_frozen, 1'b1);
		i_core_supply_low = 1'b0;
		tick(2);
		chk(o_ram_frozen, 1'b0);
		{i_ram_write_n, i_ram_select} = 2'h2;
		pd(1'b0, 1'b0);
		i_nmi_pin_n = 1'b0;
		i_main_regulator_off_bit = 1'b0;
		pd(1'b0, 1'b0);
		i_main_regulator_off_bit = 1'b1;
		pd(1'b0, 1'b1);
		chk(o_protected_active, 1'b1);
		chk(o_main_osc_en, 1'b1);
		i_partner.set_irq(0, 1'b1);
		{i_rtc_irq, i_can_activity, i_i2c_activity} = 3'h7;
		tick(20);
		chk(o_core_clk_en, 1'b0);
		{i_rtc_irq, i_can_activity, i_i2c_activity} = 3'h0;
		i_partner.set_irq(0, 1'b0);
		wake(4);
		i_nmi_pin_n = 1'b1;
		i_partner.set_irq(2, 1'b1);
		pd(1'b1, 1'b0);
		i_partner.set_irq(2, 1'b0);
		for (int k = 0; k < 5; k++) begin
			pd(1'b1, 1'b1);
			chk(o_main_osc_en, 1'b1);
			wake(k);
		end
		i_irq_active_high[3] = 1'b0;
		pd(1'b1, 1'b0);
		i_irq_enable[3] = 1'b0;
		pd(1'b1, 1'b1);
		wake(2);
		{i_irq_enable[3], i_irq_active_high[3]} = 2'h3;
		i_lp_osc_running = 1'b1;
		tick(12);
		chk(o_rtc_on_lp, 1'b1);
		pd(1'b1, 1'b1);
		chk(o_main_osc_en, 1'b0);
		chk(o_rtc_count_en, 1'b1);
		wake(1);
		stby(1'b1);
		i_lp_ref_disable = 1'b1;
		tick(2);
		chk(o_rtc_on_lp, 1'b0);
		stby(1'b0);
		end_sim();
	end
endmodule : tb_top
`default_nettype wire

// ===== bench/wake_partner.sv
`timescale 1ns/10ps
`default_nettype none
module wake_partner #(
	parameter int N = 8
) (
	input  wire logic         i_mclk,
	output var  logic         o_reset_input_pin_n,
	output var  logic [N-1:0] o_fast_external_irq_pin
);
	initial begin
		o_reset_input_pin_n     = 1'b0;
		o_fast_external_irq_pin = '0;
	end
	// Reset pin moves only as a clean level, off the sampling edge
	task automatic set_reset(input logic v);
		@(negedge i_mclk);
		o_reset_input_pin_n = v;
	endtask : set_reset
	// Caller holds a wake level for the minimum width
	task automatic set_irq(input int idx, input logic v);
		@(negedge i_mclk);
		o_fast_external_irq_pin[idx] = v;
	endtask : set_irq
endmodule : wake_partner
`default_nettype wire

// ===== hdl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_mclk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			stage1 <= '0;
			o_sync <= '0;
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule : pin_sync
`default_nettype wire

// ===== hdl/pwr_ctl.sv
`timescale 1ns/10ps
`default_nettype none
`include "pwr_ctl_map.svh"
module pwr_ctl
	import pwr_ctl_pkg::*;
#(
	parameter int N_IRQ     = `IRQ_PINS,
	parameter int LP_DETECT = `LP_DETECT_CYC
) (
	input  wire logic             i_mclk,
	input  wire logic             i_rst,
	input  wire logic             i_reset_input_pin_n,
	input  wire logic             i_power_down_instruction,
	input  wire logic [15:0]      i_system_control_register,
	input  wire logic             i_main_regulator_off_bit,
	input  wire logic             i_nmi_pin_n,
	input  wire logic [N_IRQ-1:0] i_fast_external_irq_pin,
	input  wire logic [N_IRQ-1:0] i_irq_enable,
	input  wire logic [N_IRQ-1:0] i_irq_active_high,
	input  wire logic             i_rtc_irq,
	input  wire logic             i_can_activity,
	input  wire logic             i_i2c_activity,
	input  wire logic             i_lp_osc_running,
	input  wire logic             i_lp_ref_disable,
	input  wire logic             i_retained_ram_enable,
	input  wire logic             i_core_supply_low,
	input  wire logic             i_main_supply_off,
	input  wire logic             i_ram_write_n,
	input  wire logic             i_ram_select,
	output logic                  o_core_clk_en,
	output logic                  o_main_osc_en,
	output logic                  o_rtc_on_lp,
	output logic                  o_rtc_count_en,
	output logic                  o_pd_entered,
	output logic                  o_pd_refused,
	output logic                  o_protected_active,
	output logic                  o_ram_frozen,
	output logic                  o_ram_on_standby_supply,
	output logic                  o_ram_write_n,
	output logic                  o_ram_select,
	output logic                  o_standby_retain_only
);
	pd_state_t     state;
	wake_src_t     wake;
	clk_ctl_t      clk;
	ram_ctl_t      ram;
	logic          rst_pin_n_s;
	logic          nmi_n_s;
	logic [N_IRQ-1:0] irq_s;
	logic [N_IRQ-1:0] irq_active;
	logic [N_IRQ-1:0] irq_wide;
	logic          lp_s;
	logic          any_enabled_active;
	logic          variant_intr;
	logic          lp_ref;
	localparam int LPW = $clog2(LP_DETECT + 1);
	logic [LPW-1:0] lp_cnt;
	logic          in_reset;
	logic          in_reset_d;
	logic          ext_reset;
	logic          stby_hold;

	// Widths the logic cannot serve are refused at elaboration
	if (N_IRQ < 1 || N_IRQ > 16) begin : g_bad_irq
		$error("pwr_ctl: N_IRQ out of range");
	end
	if (LP_DETECT < 1) begin : g_bad_detect
		$error("pwr_ctl: LP_DETECT must be at least one");
	end

	pin_sync #(.WIDTH(3 + N_IRQ)) u_sync (
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_async ({i_reset_input_pin_n, i_nmi_pin_n, i_lp_osc_running, i_fast_external_irq_pin}),
		.o_sync  ({rst_pin_n_s, nmi_n_s, lp_s, irq_s})
	);

	genvar g;
	generate
		for (g = 0; g < N_IRQ; g++) begin : g_irq
			assign irq_active[g] = i_irq_active_high[g] ? irq_s[g] : !irq_s[g];
			wake_filter #(.MIN_CYC(`WAKE_MIN_CYC)) u_filt (
				.i_mclk  (i_mclk),
				.i_rst   (i_rst),
				.i_level (irq_active[g] & i_irq_enable[g]),
				.o_valid (irq_wide[g])
			);
		end
	endgenerate

	assign any_enabled_active = |(irq_active & i_irq_enable);
	assign variant_intr = i_system_control_register[`PD_VARIANT_BIT];
	assign ext_reset    = !rst_pin_n_s;
	assign in_reset     = i_rst || ext_reset;

	assign wake.fast_irq = |irq_wide;
	assign wake.rtc      = i_rtc_irq;
	assign wake.can      = i_can_activity;
	assign wake.i2c      = i_i2c_activity;

	// Power-down entry and exit
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state <= PD_RUN;
		end else begin
			case (state)
				PD_RUN: begin
					if (i_power_down_instruction && i_main_regulator_off_bit) begin
						if (!variant_intr && !nmi_n_s)
							state <= PD_PROTECTED;
						else if (variant_intr && !any_enabled_active)
							state <= PD_INTERRUPTIBLE;
					end
				end
				PD_PROTECTED: begin
					if (ext_reset)
						state <= PD_RUN;
				end
				PD_INTERRUPTIBLE: begin
					if (ext_reset || (|wake))
						state <= PD_RUN;
				end
				default: state <= PD_RUN;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_pd_entered <= 1'b0;
			o_pd_refused <= 1'b0;
		end else begin
			o_pd_entered <= (state == PD_RUN) && i_power_down_instruction
				&& i_main_regulator_off_bit
				&& ((!variant_intr && !nmi_n_s) || (variant_intr && !any_enabled_active));
			o_pd_refused <= (state == PD_RUN) && i_power_down_instruction
				&& !((!variant_intr && !nmi_n_s) || (variant_intr && !any_enabled_active));
		end
	end

	// Low-power oscillator detection, kept until software disables it
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			lp_cnt <= '0;
			lp_ref <= 1'b0;
		end else begin
			if (!lp_s)
				lp_cnt <= '0;
			else if (lp_cnt != LPW'(LP_DETECT))
				lp_cnt <= lp_cnt + 1'b1;
			if (i_lp_ref_disable)
				lp_ref <= 1'b0;
			else if (lp_cnt == LPW'(LP_DETECT))
				lp_ref <= 1'b1;
		end
	end

	always_comb begin
		clk.core_clk_en  = (state == PD_RUN);
		clk.main_osc_en  = !((state != PD_RUN) && lp_ref) && !i_main_supply_off;
		clk.rtc_on_lp    = lp_ref;
		clk.rtc_count_en = i_main_supply_off ? lp_ref : 1'b1;
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_core_clk_en  <= 1'b1;
			o_main_osc_en  <= 1'b1;
			o_rtc_on_lp    <= 1'b0;
			o_rtc_count_en <= 1'b1;
		end else begin
			o_core_clk_en  <= clk.core_clk_en;
			o_main_osc_en  <= clk.main_osc_en;
			o_rtc_on_lp    <= clk.rtc_on_lp;
			o_rtc_count_en <= clk.rtc_count_en;
		end
	end

	assign o_protected_active = (state == PD_PROTECTED);

	// Retained RAM supply switching and freeze
	always_ff @(posedge i_mclk) begin
		if (i_rst)
			in_reset_d <= 1'b1;
		else
			in_reset_d <= ext_reset;
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ram.on_standby_supply <= 1'b1;
		end else if (ext_reset) begin
			ram.on_standby_supply <= 1'b1;
		end else if (in_reset_d) begin
			ram.on_standby_supply <= 1'b0;
		end
	end

	// A freeze taken while the core supply is low holds whatever the enable bit reads
	always_ff @(posedge i_mclk) begin
		if (i_rst)
			stby_hold <= 1'b0;
		else
			stby_hold <= i_core_supply_low && (stby_hold || !i_retained_ram_enable);
	end

	always_comb begin
		// A dip with the enable bit set freezes only if stby_hold was taken earlier in the dip
		ram.frozen = !i_retained_ram_enable || (i_core_supply_low && stby_hold);
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_ram_frozen            <= 1'b1;
			o_ram_on_standby_supply <= 1'b1;
			o_ram_write_n           <= 1'b1;
			o_ram_select            <= 1'b0;
			o_standby_retain_only   <= 1'b0;
		end else begin
			o_ram_frozen            <= ram.frozen;
			o_ram_on_standby_supply <= ram.on_standby_supply;
			o_ram_write_n           <= ram.frozen ? 1'b1 : i_ram_write_n;
			o_ram_select            <= ram.frozen ? 1'b0 : i_ram_select;
			o_standby_retain_only   <= i_main_supply_off && in_reset;
		end
	end

	sequence pd_request_s;
		state == PD_RUN && i_power_down_instruction && i_main_regulator_off_bit;
	endsequence

	sequence reset_release_s;
		ext_reset ##1 !ext_reset;
	endsequence

	sequence lp_stable_s;
		lp_cnt == LPW'(LP_DETECT) && !i_lp_ref_disable;
	endsequence

	chk_protected_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state == PD_PROTECTED && !ext_reset && (|wake)) |=> state == PD_PROTECTED)
		else $error("protected power-down left without reset");

	chk_reset_exit: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state == PD_PROTECTED && ext_reset) |=> state == PD_RUN)
		else $error("protected power-down ignored reset");

	chk_nmi_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state == PD_RUN && i_power_down_instruction && nmi_n_s && !variant_intr)
		|=> state == PD_RUN)
		else $error("protected power-down entered with nmi high");

	chk_protected_entry: assert property (@(posedge i_mclk) disable iff (i_rst)
		pd_request_s ##0 (!variant_intr && !nmi_n_s)
		|=> state == PD_PROTECTED && o_pd_entered)
		else $error("protected power-down not entered");

	chk_irq_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state == PD_RUN && i_power_down_instruction && any_enabled_active)
		|=> state != PD_INTERRUPTIBLE)
		else $error("interruptible power-down entered with active pin");

	chk_intr_entry: assert property (@(posedge i_mclk) disable iff (i_rst)
		pd_request_s ##0 (variant_intr && !any_enabled_active)
		|=> state == PD_INTERRUPTIBLE && o_pd_entered)
		else $error("interruptible power-down not entered");

	chk_regoff_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state == PD_RUN && i_power_down_instruction && !i_main_regulator_off_bit)
		|=> state == PD_RUN && !o_pd_entered)
		else $error("power-down entered with regulator still on");

	chk_wake_exit: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state == PD_INTERRUPTIBLE
			&& (i_rtc_irq || i_can_activity || i_i2c_activity || ext_reset))
		|=> state == PD_RUN)
		else $error("interruptible power-down ignored wake");

	chk_fast_wake: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state == PD_INTERRUPTIBLE && (|irq_wide)) |=> state == PD_RUN)
		else $error("interruptible power-down ignored fast interrupt");

	chk_intr_stay: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state == PD_INTERRUPTIBLE && !ext_reset && !(|wake)) |=> state == PD_INTERRUPTIBLE)
		else $error("interruptible power-down left without wake");

	chk_run_clock: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state == PD_RUN) |=> o_core_clk_en)
		else $error("core clock stopped outside power-down");

	chk_clock_stop: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state != PD_RUN) |=> !o_core_clk_en)
		else $error("core clock running in power-down");

	chk_osc_select: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state != PD_RUN && !i_main_supply_off) |=> o_main_osc_en == !$past(lp_ref))
		else $error("main oscillator state wrong in power-down");

	chk_lp_stop: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state != PD_RUN && lp_ref) |=> !o_main_osc_en)
		else $error("main oscillator running in power-down on low-power reference");

	chk_osc_kept: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state != PD_RUN && !lp_ref && !i_main_supply_off) |=> o_main_osc_en)
		else $error("main oscillator stopped without low-power reference");

	chk_lp_adopt: assert property (@(posedge i_mclk) disable iff (i_rst)
		lp_stable_s |=> lp_ref ##1 o_rtc_on_lp)
		else $error("low-power reference not adopted");

	chk_lp_disable: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_lp_ref_disable |=> !lp_ref)
		else $error("low-power reference kept after disable");

	chk_ram_standby: assert property (@(posedge i_mclk) disable iff (i_rst)
		ext_reset |=> ##1 o_ram_on_standby_supply)
		else $error("RAM supply not moved to standby on reset");

	chk_supply_return: assert property (@(posedge i_mclk) disable iff (i_rst)
		reset_release_s |=> ##1 !o_ram_on_standby_supply)
		else $error("RAM supply not returned to main");

	chk_freeze_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
		!i_retained_ram_enable |=> o_ram_frozen && o_ram_write_n)
		else $error("RAM not frozen with enable clear");

	chk_low_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_core_supply_low && stby_hold) |=> o_ram_frozen)
		else $error("RAM unfrozen while core supply low");

	chk_dip_open: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_core_supply_low && i_retained_ram_enable && !stby_hold) |=> !o_ram_frozen)
		else $error("RAM frozen by supply dip with enable set");

	chk_strobe_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
		ram.frozen |=> o_ram_write_n && !o_ram_select)
		else $error("RAM strobe passed while frozen");

	chk_strobe_pass: assert property (@(posedge i_mclk) disable iff (i_rst)
		!ram.frozen |=> o_ram_write_n == $past(i_ram_write_n))
		else $error("RAM write strobe not passed while open");

	chk_standby_count: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_main_supply_off |=> o_rtc_count_en == $past(lp_ref))
		else $error("RTC count enable wrong with main supply off");

	chk_supply_osc: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_main_supply_off |=> !o_main_osc_en)
		else $error("main oscillator enabled with main supply off");

	chk_retain_only: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_main_supply_off && in_reset) |=> o_standby_retain_only)
		else $error("standby retention not flagged");
endmodule : pwr_ctl
`default_nettype wire

// ===== hdl/pwr_ctl_map.svh
`ifndef PWR_CTL_MAP_SVH
`define PWR_CTL_MAP_SVH
`define PD_VARIANT_BIT     5
`define IRQ_PINS           8
`define WAKE_MIN_NS        40
`define MCLK_PERIOD_NS     4
`define WAKE_MIN_CYC       ((`WAKE_MIN_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define LP_DETECT_CYC      16
`define RETAINED_KBYTES    16
`endif

// ===== hdl/pwr_ctl_pkg.sv
package pwr_ctl_pkg;
	typedef enum logic [1:0] {
		PD_RUN,
		PD_PROTECTED,
		PD_INTERRUPTIBLE
	} pd_state_t;

	typedef struct packed {
		logic fast_irq;
		logic rtc;
		logic can;
		logic i2c;
	} wake_src_t;

	typedef struct packed {
		logic core_clk_en;
		logic main_osc_en;
		logic rtc_on_lp;
		logic rtc_count_en;
	} clk_ctl_t;

	typedef struct packed {
		logic frozen;
		logic on_standby_supply;
	} ram_ctl_t;
endpackage : pwr_ctl_pkg

// ===== hdl/wake_filter.sv
`timescale 1ns/10ps
`default_nettype none
`include "pwr_ctl_map.svh"
module wake_filter #(
	parameter int MIN_CYC = `WAKE_MIN_CYC
) (
	input  wire logic i_mclk,
	input  wire logic i_rst,
	input  wire logic i_level,
	output logic      o_valid
);
	localparam int CW = $clog2(MIN_CYC + 1);
	logic [CW-1:0] count;

	if (MIN_CYC < 1) begin : g_bad_min
		$error("wake_filter: MIN_CYC must be at least one");
	end

	// Pulse must stand the minimum width before it counts as a wake
	always_ff @(posedge i_mclk) begin
		if (i_rst || !i_level)
			count <= '0;
		else if (count != CW'(MIN_CYC))
			count <= count + 1'b1;
	end

	assign o_valid = (count == CW'(MIN_CYC));
endmodule : wake_filter
`default_nettype wire
